// ==== rtl/lfw_pkg.sv ====
/*
  Constants, types and timing figures of the LF wake-up sequencer.
  Assumes the core clock runs at CLK_MHZ and a 125 kHz carrier.
*/
package lfw_pkg;
  localparam int NCH = 3;
  localparam int CLK_MHZ = 25;
  // Carrier period and derived cycle counts
  localparam int CAR_PER_NS = 8000;
  localparam int CAR_CYC = (CAR_PER_NS * CLK_MHZ) / 1000;
  localparam int PRE_PERIODS = 192;
  localparam int MISS_MAX = 3;
  localparam int MISS_CYC = (MISS_MAX + 1) * CAR_CYC + CAR_CYC / 2;
  localparam int GAP_PERIODS = 3;
  localparam int GAP_CYC = GAP_PERIODS * CAR_CYC;
  localparam int ET_W = 10;
  // Header and oscillator based timing
  localparam int HDR_EDGES = 8;
  localparam int HDR_SEG_US = 500;
  localparam int HDR_SEG_CYC = HDR_SEG_US * CLK_MHZ;
  localparam int HDR_TMO_MS = 2;
  localparam int HDR_TMO_CYC = HDR_TMO_MS * CLK_MHZ * 1000;
  localparam int NOSIG_MS = 20;
  localparam int NOSIG_CYC = NOSIG_MS * CLK_MHZ * 1000;
  localparam int WDOG_MS = 360;
  localparam int WDOG_CYC = WDOG_MS * CLK_MHZ * 1000;
  localparam int TMR_W = 24;
  localparam int SEG_W = 16;
  // Gain counter: zero is highest sensitivity
  localparam logic [7:0] GAIN_INIT = 8'h00;
  localparam logic [7:0] GAIN_LOW = 8'hFF;
  localparam logic [7:0] HOLD_INIT = 8'h00;
  localparam logic [2:0] AGC_UP_DIV = 3'h7;
  // Serial command word
  localparam int SER_BITS = 8;
  localparam int CMD_RD_BIT = 4;
  localparam int CMD_SRST_BIT = 3;
  localparam logic [1:0] IFRST_LAST = 2'h3;
  localparam logic [2:0] BLANK_CYC = 3'h7;

  typedef enum logic [1:0] {
    LFW_LISTEN = 2'h0,
    LFW_PREOK = 2'h1,
    LFW_HDR = 2'h3,
    LFW_WAKE = 2'h2
  } lfw_state_t;

  typedef struct packed {
    logic [NCH-1:0] car;
    logic [NCH-1:0] amp;
    logic scl;
    logic sda;
    logic tog;
  } lfw_pins_t;
endpackage

// ==== rtl/lfw_sync.sv ====
/*
  Three-stage synchroniser with agreement filter.
  Assumes inputs are asynchronous to clk; output changes once stages 2 and 3 agree.
*/
`timescale 1ns/1ps
module lfw_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: take stage 3 only where stages 2 and 3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
  end
endmodule // lfw_sync

// ==== rtl/lfw_top.sv ====
/*
  LF wake-up sequencer: preamble check, header detection, wake-up data,
  gain counter, resets and the controller's two-wire slave interface.
  Assumes digitised carrier and over-reference flags per channel, a
  pull-up on the data line, and the serial clock idle high.
*/
`timescale 1ns/1ps
module lfw_top #(
  parameter int unsigned HDR_SEG = lfw_pkg::HDR_SEG_CYC,
  parameter int unsigned HDR_TMO = lfw_pkg::HDR_TMO_CYC,
  parameter int unsigned NOSIG_TMO = lfw_pkg::NOSIG_CYC,
  parameter int unsigned WDOG_TMO = lfw_pkg::WDOG_CYC
) (
  // System
  input wire logic MCLK,
  input wire logic RSTN,
  // Receiver front end
  input wire logic [lfw_pkg::NCH-1:0] CARRIER,
  input wire logic [lfw_pkg::NCH-1:0] AMP_OVER,
  output logic OSC_RUN,
  // Two-wire link
  input wire logic SERIAL_CLOCK_N,
  input wire logic DATA_WAKEUP_IO_N_PIN,
  output logic DATA_WAKEUP_IO_N_VAL,
  output logic DATA_WAKEUP_IO_N_EN_N
);
  import lfw_pkg::*;

  localparam logic [SEG_W-1:0] SEG_LIM = SEG_W'(HDR_SEG);
  localparam logic [TMR_W-1:0] HDR_LIM = TMR_W'(HDR_TMO);
  localparam logic [TMR_W-1:0] NOSIG_LIM = TMR_W'(NOSIG_TMO);
  localparam logic [TMR_W-1:0] WDOG_LIM = TMR_W'(WDOG_TMO);
  localparam logic [ET_W-1:0] MISS_LIM = ET_W'(MISS_CYC);
  localparam logic [ET_W-1:0] GAP_LIM = ET_W'(GAP_CYC);
  localparam logic [7:0] PRE_LAST = 8'(PRE_PERIODS - 1);
  localparam logic [3:0] HDR_LAST = 4'(HDR_EDGES - 1);

  if (HDR_SEG >= 2 ** SEG_W || HDR_SEG == 0 || WDOG_TMO >= 2 ** TMR_W ||
      NOSIG_TMO >= 2 ** TMR_W || HDR_TMO >= 2 ** TMR_W || HDR_TMO == 0) begin : g_chk
    $error("lfw_top: timing parameter out of range");
  end

  // Serial domain state
  logic ser_rst_n_q;
  logic ser_act_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] cmd_sh_q;
  logic [7:0] cmd_word_q;
  logic cmd_tog_q;
  logic rd_mode_q;
  logic out_ld_q;
  logic [7:0] out_sh_q;
  logic [7:0] new_word;
  logic last_bit;

  // Core domain state
  lfw_pins_t raw, syn;
  lfw_state_t st_q, st_d;
  logic tog_seen_q;
  logic [2:0] blank_q;
  logic cmd_ev, soft_req, rd_req, if_req;
  logic sda_prev_q;
  logic [1:0] ifp_cnt_q;
  logic car_any, car_prev_q, car_edge;
  logic [ET_W-1:0] et_q;
  logic gap_q, gap_prev_q, gap_edge;
  logic [7:0] pre_cnt_q;
  logic [TMR_W-1:0] tmr_q, wdog_q;
  logic [SEG_W-1:0] seg_q;
  logic [3:0] hdr_cnt_q;
  logic [7:0] gain_q, gain_hold_q;
  logic [2:0] div_q;
  logic over;
  logic data_q;

  // Serial domain: clocked by the controller only
  assign new_word = {cmd_sh_q[6:0], DATA_WAKEUP_IO_N_PIN};
  assign last_bit = (bit_cnt_q == 3'(SER_BITS - 1));

  // Falling edge marks a started transfer; a stray rising edge is ignored
  always_ff @(negedge SERIAL_CLOCK_N or negedge ser_rst_n_q) begin
    if (!ser_rst_n_q) begin
      ser_act_q <= 1'b0;
    end else begin
      ser_act_q <= 1'b1;
    end
  end

  always_ff @(posedge SERIAL_CLOCK_N or negedge ser_rst_n_q) begin
    if (!ser_rst_n_q) begin
      bit_cnt_q <= 3'h0;
      cmd_sh_q <= 8'h00;
    end else if (ser_act_q) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (!rd_mode_q) begin
        cmd_sh_q <= new_word;
      end
    end
  end

  // Word held stable for the core until the next command completes
  always_ff @(posedge SERIAL_CLOCK_N or negedge ser_rst_n_q) begin
    if (!ser_rst_n_q) begin
      cmd_word_q <= 8'h00;
      cmd_tog_q <= 1'b0;
    end else if (ser_act_q && !rd_mode_q && last_bit) begin
      cmd_word_q <= new_word;
      cmd_tog_q <= ~cmd_tog_q;
    end
  end

  always_ff @(posedge SERIAL_CLOCK_N or negedge ser_rst_n_q) begin
    if (!ser_rst_n_q) begin
      rd_mode_q <= 1'b0;
    end else if (ser_act_q && last_bit) begin
      rd_mode_q <= !rd_mode_q && new_word[CMD_RD_BIT];
    end
  end

  // Hold register is static by then: the access gap covers the core update
  always_ff @(negedge SERIAL_CLOCK_N or negedge ser_rst_n_q) begin
    if (!ser_rst_n_q) begin
      out_sh_q <= 8'h00;
      out_ld_q <= 1'b0;
    end else if (!rd_mode_q) begin
      out_ld_q <= 1'b0;
    end else if (!out_ld_q) begin
      out_sh_q <= gain_hold_q;
      out_ld_q <= 1'b1;
    end else begin
      out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  // Core domain inputs
  assign raw = '{car: CARRIER, amp: AMP_OVER, scl: SERIAL_CLOCK_N,
                 sda: DATA_WAKEUP_IO_N_PIN, tog: cmd_tog_q};

  lfw_sync #(
    .W($bits(lfw_pins_t))
  ) u_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .d(raw),
    .q(syn)
  );

  // Command arrival; events masked while the cleared toggle settles
  assign cmd_ev = (syn.tog ^ tog_seen_q) && (blank_q == 3'h0);
  assign soft_req = cmd_ev && cmd_word_q[CMD_SRST_BIT];
  assign rd_req = cmd_ev && cmd_word_q[CMD_RD_BIT];

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tog_seen_q <= 1'b0;
    end else begin
      tog_seen_q <= syn.tog;
    end
  end

  // Interface recovery: data pulses while the clock is low
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sda_prev_q <= 1'b1;
      ifp_cnt_q <= 2'h0;
    end else begin
      sda_prev_q <= syn.sda;
      if (syn.scl) begin
        ifp_cnt_q <= 2'h0;
      end else if (syn.sda && !sda_prev_q) begin
        ifp_cnt_q <= ifp_cnt_q + 2'h1;
      end
    end
  end

  assign if_req = !syn.scl && syn.sda && !sda_prev_q && (ifp_cnt_q == IFRST_LAST);

  // Serial reset driven from a flop so it cannot glitch
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ser_rst_n_q <= 1'b0;
      blank_q <= BLANK_CYC;
    end else begin
      ser_rst_n_q <= !(soft_req || if_req);
      if (soft_req || if_req) begin
        blank_q <= BLANK_CYC;
      end else if (blank_q != 3'h0) begin
        blank_q <= blank_q - 3'h1;
      end
    end
  end

  // Carrier edges and gap detection on the merged channels
  assign car_any = |syn.car;
  assign car_edge = car_any && !car_prev_q;
  assign gap_edge = gap_q ^ gap_prev_q;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      car_prev_q <= 1'b0;
      et_q <= MISS_LIM;
    end else begin
      car_prev_q <= car_any;
      if (car_edge) begin
        et_q <= '0;
      end else if (et_q != MISS_LIM) begin
        et_q <= et_q + ET_W'(1);
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      gap_q <= 1'b1;
      gap_prev_q <= 1'b1;
    end else begin
      gap_q <= (et_q >= GAP_LIM) && !car_edge;
      gap_prev_q <= gap_q;
    end
  end

  // Preamble qualification
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_cnt_q <= 8'h00;
    end else if (st_q != LFW_LISTEN || et_q == MISS_LIM) begin
      pre_cnt_q <= 8'h00;
    end else if (car_edge) begin
      pre_cnt_q <= pre_cnt_q + 8'h01;
    end
  end

  // Sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      LFW_LISTEN: begin
        if (car_edge && pre_cnt_q == PRE_LAST) begin
          st_d = LFW_PREOK;
        end
      end
      LFW_PREOK: begin
        if (gap_q && !gap_prev_q) begin
          st_d = LFW_HDR;
        end
      end
      LFW_HDR: begin
        if (tmr_q >= HDR_LIM) begin
          st_d = LFW_LISTEN;
        end else if (gap_edge && hdr_cnt_q == HDR_LAST) begin
          st_d = LFW_WAKE;
        end
      end
      LFW_WAKE: begin
        if (tmr_q >= NOSIG_LIM) begin
          st_d = LFW_LISTEN;
        end
      end
      default: begin
        st_d = LFW_LISTEN;
      end
    endcase
    if (st_q != LFW_LISTEN && wdog_q >= WDOG_LIM) begin
      st_d = LFW_LISTEN;
    end
    if (soft_req) begin
      st_d = LFW_LISTEN;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= LFW_LISTEN;
    end else begin
      st_q <= st_d;
    end
  end

  // Oscillator time base: runs only in header and wake phases
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tmr_q <= '0;
    end else if (st_d != st_q || (st_q == LFW_WAKE && car_edge)) begin
      tmr_q <= '0;
    end else if (st_q == LFW_HDR || st_q == LFW_WAKE) begin
      tmr_q <= tmr_q + TMR_W'(1);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wdog_q <= '0;
    end else if (st_d == LFW_LISTEN) begin
      wdog_q <= '0;
    end else begin
      wdog_q <= wdog_q + TMR_W'(1);
    end
  end

  // Header edge counting; a segment too long restarts the count
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      seg_q <= '0;
      hdr_cnt_q <= 4'h0;
    end else if (st_q != LFW_HDR) begin
      seg_q <= '0;
      hdr_cnt_q <= 4'h0;
    end else if (gap_edge) begin
      seg_q <= '0;
      hdr_cnt_q <= hdr_cnt_q + 4'h1;
    end else if (seg_q >= SEG_LIM) begin
      hdr_cnt_q <= 4'h0;
    end else begin
      seg_q <= seg_q + SEG_W'(1);
    end
  end

  // Gain counter, frozen in gaps; any channel over reference lowers sensitivity
  assign over = |syn.amp;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      gain_q <= GAIN_INIT;
      div_q <= 3'h0;
    end else if (st_d == LFW_LISTEN) begin
      gain_q <= GAIN_INIT;
      div_q <= 3'h0;
    end else if (car_edge) begin
      div_q <= div_q + 3'h1;
      if (over && div_q[0] && gain_q != GAIN_LOW) begin
        gain_q <= gain_q + 8'h01;
      end else if (!over && div_q == AGC_UP_DIV && gain_q != GAIN_INIT) begin
        gain_q <= gain_q - 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      gain_hold_q <= HOLD_INIT;
    end else if (soft_req) begin
      gain_hold_q <= HOLD_INIT;
    end else if (rd_req) begin
      gain_hold_q <= gain_q;
    end
  end

  // Wake data: low in gaps, high with carrier, released otherwise
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      data_q <= 1'b1;
      OSC_RUN <= 1'b0;
    end else begin
      data_q <= (st_d == LFW_WAKE) ? !gap_q : 1'b1;
      OSC_RUN <= (st_d == LFW_HDR) || (st_d == LFW_WAKE);
    end
  end

  // Read-out has the line over wake data
  assign DATA_WAKEUP_IO_N_VAL = rd_mode_q ? out_sh_q[7] : data_q;
  assign DATA_WAKEUP_IO_N_EN_N = !(rd_mode_q || st_q == LFW_WAKE);
endmodule // lfw_top

// ==== dv/lfw_checker.sv ====
/*
  Checker: timing relations of the wake-up sequencer seen at its top ports.
  Assumes all carrier channels switch together and the bind hands on the timer parameters.
*/
`timescale 1ns/1ps
module lfw_checker #(
  parameter int unsigned HDR_TMO = lfw_pkg::HDR_TMO_CYC,
  parameter int unsigned NOSIG_TMO = lfw_pkg::NOSIG_CYC,
  parameter int unsigned WDOG_TMO = lfw_pkg::WDOG_CYC
) (
  // System
  input wire logic MCLK,
  input wire logic RSTN,
  // Front end
  input wire logic [lfw_pkg::NCH-1:0] CARRIER,
  input wire logic [lfw_pkg::NCH-1:0] AMP_OVER,
  input wire logic OSC_RUN,
  // Link
  input wire logic SERIAL_CLOCK_N,
  input wire logic DATA_WAKEUP_IO_N_PIN,
  input wire logic DATA_WAKEUP_IO_N_VAL,
  input wire logic DATA_WAKEUP_IO_N_EN_N
);
  import lfw_pkg::*;
  logic [NCH-1:0] car_q;
  logic [23:0] age_q, hi_q, pc_q, hc_q, oc_q, qc_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // Carrier age, edge count and phase timers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      car_q <= '0;
      age_q <= '0;
      hi_q <= '0;
      pc_q <= '0;
      hc_q <= '0;
      oc_q <= '0;
      qc_q <= '0;
    end else begin
      car_q <= CARRIER;
      // Gap and miss limits run from the last rising edge, not from carrier off
      age_q <= (CARRIER[0] && !car_q[0]) ? '0 : age_q + 1'b1;
      hi_q <= (age_q >= GAP_CYC) ? '0 : hi_q + 1'b1;
      pc_q <= (age_q >= MISS_CYC) ? '0 : pc_q + 24'(CARRIER[0] && !car_q[0]);
      hc_q <= (OSC_RUN && DATA_WAKEUP_IO_N_EN_N) ? hc_q + 1'b1 : '0;
      oc_q <= OSC_RUN ? oc_q + 1'b1 : '0;
      qc_q <= (CARRIER != car_q) ? '0 : qc_q + 1'b1;
    end
  end

  sequence s_wake_on;
    $fell(DATA_WAKEUP_IO_N_EN_N) ##0 OSC_RUN;
  endsequence

  a_idle_after_reset: assert property ($rose(RSTN) |-> !OSC_RUN && DATA_WAKEUP_IO_N_EN_N)
    else $error("outputs not idle after reset");
  a_osc_at_gap: assert property ($rose(OSC_RUN) |-> age_q >= GAP_CYC && age_q <= GAP_CYC + 16)
    else $error("oscillator start not at burst end");
  a_pre_count: assert property ($rose(OSC_RUN) |-> pc_q >= PRE_PERIODS)
    else $error("oscillator started on short preamble");
  a_hdr_limit: assert property (hc_q <= HDR_TMO + 16)
    else $error("header phase outlived its time-out");
  a_wdog_limit: assert property (oc_q <= WDOG_TMO)
    else $error("active phase outlived the watchdog");
  a_nosig_limit: assert property (qc_q > NOSIG_TMO + 16 |-> !OSC_RUN)
    else $error("no reset after quiet input");
  a_wake_gap: assert property (s_wake_on |-> !DATA_WAKEUP_IO_N_VAL)
    else $error("wake-up not pulled low in gap");
  a_data_high: assert property (OSC_RUN && !DATA_WAKEUP_IO_N_EN_N
    && hi_q >= 2 * CAR_CYC && age_q < GAP_CYC |-> DATA_WAKEUP_IO_N_VAL)
    else $error("data low during carrier");
  a_data_low: assert property (OSC_RUN && !DATA_WAKEUP_IO_N_EN_N
    && age_q >= GAP_CYC + 16 |-> !DATA_WAKEUP_IO_N_VAL)
    else $error("data high during gap");
endmodule // lfw_checker

bind lfw_top lfw_checker #(.HDR_TMO(HDR_TMO), .NOSIG_TMO(NOSIG_TMO), .WDOG_TMO(WDOG_TMO))
  lfw_checker_inst (.MCLK(MCLK), .RSTN(RSTN), .CARRIER(CARRIER), .AMP_OVER(AMP_OVER),
  .OSC_RUN(OSC_RUN), .SERIAL_CLOCK_N(SERIAL_CLOCK_N),
  .DATA_WAKEUP_IO_N_PIN(DATA_WAKEUP_IO_N_PIN), .DATA_WAKEUP_IO_N_VAL(DATA_WAKEUP_IO_N_VAL),
  .DATA_WAKEUP_IO_N_EN_N(DATA_WAKEUP_IO_N_EN_N));

// ==== dv/lfw_host.sv ====
/*
  Controller model: master of the two-wire link, 80 ns serial clock.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
module lfw_host (
  // Link pins
  output logic scl_n,
  output logic sda,
  output logic sda_oe,
  input wire logic pin
);
  initial begin
    scl_n = 1'b1;
    sda = 1'b1;
    sda_oe = 1'b0;
  end

  // One word MSB first; clock idles high between words
  task automatic xfer(input logic [7:0] tx, input logic rd, output logic [7:0] rx);
    #7;
    for (int i = 7; i >= 0; i--) begin
      scl_n = 1'b0;
      sda_oe = !rd;
      sda = tx[i];
      #40;
      // Sample before the rise: the device may turn the line round on it
      rx[i] = pin;
      scl_n = 1'b1;
      #40;
    end
    sda_oe = 1'b0;
  endtask

  // Clock held low, four data pulses; pulses wide enough to pass the filter
  task automatic recover();
    scl_n = 1'b0;
    sda_oe = 1'b1;
    sda = 1'b0;
    repeat (4) begin
      #200;
      sda = 1'b1;
      #200;
      sda = 1'b0;
    end
    #200;
    // Clock up first, so releasing the line adds no counted pulse
    scl_n = 1'b1;
    #200;
    sda_oe = 1'b0;
  endtask
endmodule // lfw_host

// ==== dv/lfw_top_tb.sv ====
/*
  Testbench of the wake-up sequencer: link reads, wake-up, soft reset, header time-out.
  Assumes the host model owns the serial clock and a pull-up on the data line.
*/
`timescale 1ns/1ps
module lfw_top_tb;
  import lfw_pkg::*;
  localparam int HDR_TMO = 7000;
  localparam int NOSIG_TMO = 8000;
  logic mclk, rstn, osc_run, val, en_n, scl_n, sda, sda_oe, pin;
  logic [NCH-1:0] car, amp;
  logic [7:0] rx;
  int num_errors, tests_run, cyc;

  // Host wins while driving, else device, else pull-up
  assign pin = sda_oe ? sda : (!en_n ? val : 1'b1);

  lfw_top #(.HDR_SEG(1500), .HDR_TMO(HDR_TMO), .NOSIG_TMO(NOSIG_TMO), .WDOG_TMO(60000))
    lfw_top_inst (.MCLK(mclk), .RSTN(rstn), .CARRIER(car), .AMP_OVER(amp),
    .OSC_RUN(osc_run), .SERIAL_CLOCK_N(scl_n), .DATA_WAKEUP_IO_N_PIN(pin),
    .DATA_WAKEUP_IO_N_VAL(val), .DATA_WAKEUP_IO_N_EN_N(en_n));
  lfw_host lfw_host_inst (.scl_n(scl_n), .sda(sda), .sda_oe(sda_oe), .pin(pin));

  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %b seen %b", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic burst(input int n);
    repeat (n) begin
      car = '1;
      cyc_n(CAR_CYC / 2);
      car = '0;
      cyc_n(CAR_CYC / 2);
    end
  endtask

  // Plain command, then gain read in listen with every channel over reference
  task automatic t_link_read();
    amp = '1;
    lfw_host_inst.xfer(8'h80, 1'b0, rx);
    cyc_n(10);
    chk_bit("en_n after write", 1'b1, en_n);
    lfw_host_inst.xfer(8'h10, 1'b0, rx);
    cyc_n(10);
    chk_bit("en_n after read cmd", 1'b0, en_n);
    cyc_n(1300);
    lfw_host_inst.xfer(8'h00, 1'b1, rx);
    chk_byte("gain in listen", GAIN_INIT, rx);
    cyc_n(2);
    chk_bit("en_n after read", 1'b1, en_n);
  endtask

  // Read command left pending, then interface recovery must drop the output
  task automatic t_if_recover();
    lfw_host_inst.xfer(8'h10, 1'b0, rx);
    cyc_n(10);
    chk_bit("en_n before recovery", 1'b0, en_n);
    lfw_host_inst.recover();
    cyc_n(10);
    chk_bit("en_n after recovery", 1'b1, en_n);
  endtask

  // Preamble with a hole, header, data, then soft reset over the link
  task automatic t_wake();
    amp = 3'h1;
    burst(100);
    cyc_n(600);
    burst(100);
    cyc_n(700);
    chk_bit("osc after preamble", 1'b1, osc_run);
    chk_bit("en_n in header", 1'b1, en_n);
    repeat (4) begin
      burst(3);
      cyc_n(600);
    end
    chk_bit("en_n woken", 1'b0, en_n);
    chk_bit("data in gap", 1'b0, val);
    burst(3);
    chk_bit("data in burst", 1'b1, val);
    lfw_host_inst.xfer(8'h08, 1'b0, rx);
    cyc_n(12);
    chk_bit("osc after soft reset", 1'b0, osc_run);
    chk_bit("en_n after soft reset", 1'b1, en_n);
  endtask

  // Preamble with no header: oscillator must stop at the time-out
  task automatic t_hdr_timeout();
    int n;
    burst(195);
    n = 0;
    while (!osc_run && n < 1000) begin
      cyc_n(1);
      n++;
    end
    chk_bit("osc started", 1'b1, osc_run);
    n = 0;
    while (osc_run && n < 20000) begin
      cyc_n(1);
      n++;
    end
    chk_bit("header time-out", 1'b1, n >= HDR_TMO - 700 && n <= HDR_TMO + 50);
    chk_bit("en_n without header", 1'b1, en_n);
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    car = '0;
    amp = '0;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    cyc_n(2);
    rstn = 1'b1;
    cyc_n(10);
    chk_bit("osc idle", 1'b0, osc_run);
    t_link_read();
    t_if_recover();
    t_wake();
    t_hdr_timeout();
    complete_run();
  end
endmodule // lfw_top_tb
